// *** logic/nand_cmd_device.sv ***
// Command front end of a serial NAND die: framing, protection, busy lockout.
// Assumes sclk idles low outside frames and stands still while cs_n is high.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "spi_nand_defs.svh"
module nand_cmd_device (
  // Core clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Link to the host
  spi_link_if.device                 link,
  // Core status
  output logic                       busy,
  output logic                       write_enabled,
  output logic                       top_bottom_select,
  output logic [3:0]                 protect_range_code,
  // Array operation started or refused
  output logic                       array_op_start,
  output spi_nand_pkg::array_op_t    array_op_kind,
  output logic [15:0]                page_address,
  output logic                       protect_reject
);
  import spi_nand_pkg::*;

  // --------------------------------------------------------------------------
  // Link domain: framing and capture
  // --------------------------------------------------------------------------
  logic [2:0]  bit_cnt_q;
  logic        first_q;
  logic [7:0]  rx_sr_q;
  logic [3:0]  byte_cnt_q;
  logic [7:0]  opcode_q;
  logic [7:0]  byte1_q;
  logic [15:0] page_q;
  logic        partial_q;
  logic        frame_tgl_q;
  logic [7:0]  out_sr_q;
  logic [7:0]  st_s1_q;
  logic [7:0]  st_s2_q;
  logic [7:0]  st_s3_q;
  logic [7:0]  st_lvl_q;
  logic [7:0]  status_byte;

  wire [7:0] rx_sr_d    = {rx_sr_q[6:0], link.serial_data_in};
  wire       byte_done  = (bit_cnt_q == 3'h7);
  wire [3:0] byte_base  = first_q ? 4'h0 : byte_cnt_q;
  wire [3:0] byte_cnt_d = (byte_done && byte_base != 4'hF) ? byte_base + 4'h1 : byte_base;

  // Chip select high holds the bit counter clear, so each fall starts afresh
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_q <= 3'h0;
      first_q   <= 1'b1;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      first_q   <= 1'b0;
    end
  end

  // Captured fields survive the end of the frame so the core can judge them
  always_ff @(posedge link.sclk or posedge reset) begin
    if (reset) begin
      rx_sr_q     <= 8'h00;
      byte_cnt_q  <= 4'h0;
      opcode_q    <= 8'h00;
      byte1_q     <= 8'h00;
      page_q      <= 16'h0000;
      partial_q   <= 1'b0;
      frame_tgl_q <= 1'b0;
    end else begin
      rx_sr_q     <= rx_sr_d;
      byte_cnt_q  <= byte_cnt_d;
      partial_q   <= !byte_done;
      frame_tgl_q <= frame_tgl_q ^ first_q;
      if (byte_done && byte_base == 4'h0) begin
        opcode_q <= rx_sr_d;
      end
      if (byte_done && byte_base == 4'h1) begin
        byte1_q <= rx_sr_d;
      end
      if (byte_done && byte_base == 4'h2) begin
        page_q[15:8] <= rx_sr_d;
      end
      if (byte_done && byte_base == 4'h3) begin
        page_q[7:0] <= rx_sr_d;
      end
    end
  end

  // Status bits reach the link domain through three stages
  always_ff @(posedge link.sclk or posedge reset) begin
    if (reset) begin
      st_s1_q  <= 8'h00;
      st_s2_q  <= 8'h00;
      st_s3_q  <= 8'h00;
      st_lvl_q <= 8'h00;
    end else begin
      st_s1_q <= status_byte;
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
      if (st_s2_q == st_s3_q) begin
        st_lvl_q <= st_s3_q;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: read data out
  // --------------------------------------------------------------------------
  wire is_status_rd = (opcode_q == `OP_READ_STATUS);
  wire is_id_rd     = (opcode_q == `OP_READ_ID);
  wire [7:0] protect_byte = {1'b0, st_lvl_q[7], st_lvl_q[6:3], 2'b00};
  wire [7:0] sr_byte  = (byte1_q == `SR_ADDR_PROTECT) ? protect_byte :
                        (byte1_q == `SR_ADDR_STATUS)  ? {5'h00, st_lvl_q[2:0]} : 8'h00;
  wire [15:0] part_code = `PART_CODE;
  wire [7:0] id_byte  = (byte_cnt_q == 4'h2) ? `MAKER_CODE :
                        (byte_cnt_q == 4'h3) ? part_code[15:8] :
                        (byte_cnt_q == 4'h4) ? part_code[7:0] : 8'h00;
  wire [7:0] tx_byte  = is_id_rd ? id_byte : is_status_rd ? sr_byte : 8'h00;
  wire       tx_load  = (bit_cnt_q == 3'h0) && !first_q && (byte_cnt_q >= 4'h2);

  // Data changes on the falling edge so the host samples it settled
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      out_sr_q <= 8'h00;
    end else if (tx_load) begin
      out_sr_q <= tx_byte;
    end else begin
      out_sr_q <= {out_sr_q[6:0], 1'b0};
    end
  end

  // Status and ID reads execute nothing, so stopping mid-byte is harmless
  assign link.serial_data_out    = out_sr_q[7] & ~link.cs_n;
  assign link.serial_data_out_oe = ~link.cs_n & ~first_q & (is_status_rd | is_id_rd)
                                   & (byte_cnt_q >= 4'h2);

  // --------------------------------------------------------------------------
  // Core domain: frame end detection
  // --------------------------------------------------------------------------
  logic        cs_s1_q, cs_s2_q, cs_s3_q, cs_lvl_q;
  logic        tg_s1_q, tg_s2_q, tg_s3_q, tg_lvl_q;
  logic        seen_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      {cs_s1_q, cs_s2_q, cs_s3_q, cs_lvl_q} <= 4'hF;
      {tg_s1_q, tg_s2_q, tg_s3_q, tg_lvl_q} <= 4'h0;
    end else begin
      {cs_s1_q, cs_s2_q, cs_s3_q} <= {link.cs_n, cs_s1_q, cs_s2_q};
      {tg_s1_q, tg_s2_q, tg_s3_q} <= {frame_tgl_q, tg_s1_q, tg_s2_q};
      if (cs_s2_q == cs_s3_q) begin
        cs_lvl_q <= cs_s3_q;
      end
      if (tg_s2_q == tg_s3_q) begin
        tg_lvl_q <= tg_s3_q;
      end
    end
  end

  // A frame with no clock edges leaves the toggle alone and is ignored
  wire cs_rise   = cs_s2_q && cs_s3_q && !cs_lvl_q;
  wire new_frame = cs_rise && (tg_lvl_q != seen_q);

  // --------------------------------------------------------------------------
  // Core domain: protection decode
  // --------------------------------------------------------------------------
  logic        top_bottom_q;
  logic [3:0]  code_q;
  wire  [9:0]  block      = page_q[15:6];
  wire  [10:0] span       = 11'h001 << code_q;
  wire         all_prot   = code_q[3] && (code_q[2] || code_q[1]);
  wire         upper_hit  = {1'b0, block} >= (11'h400 - span);
  wire         lower_hit  = {1'b0, block} < span;
  wire         protected_hit = (code_q != 4'h0) &&
                               (all_prot || (top_bottom_q ? lower_hit : upper_hit));

  // --------------------------------------------------------------------------
  // Core domain: command execution
  // --------------------------------------------------------------------------
  logic        wel_q, fail_q;
  logic [11:0] busy_cnt_q;
  wire         busy_now   = (busy_cnt_q != 12'h000);
  wire         exempt     = (opcode_q == `OP_READ_STATUS) || (opcode_q == `OP_READ_ID);
  wire         accepted   = new_frame && (!busy_now || exempt);
  wire         whole      = !partial_q;
  wire         has_page   = (byte_cnt_q >= 4'h4) && whole;
  wire         is_array   = (opcode_q == `OP_BLOCK_ERASE) || (opcode_q == `OP_PROGRAM_EXEC);
  wire         array_go   = accepted && is_array && has_page && wel_q;
  wire         array_ok   = array_go && !protected_hit;
  wire         page_rd_go = accepted && (opcode_q == `OP_PAGE_DATA_READ) && has_page;
  wire         wrsr_go    = accepted && (opcode_q == `OP_WRITE_STATUS) && whole
                            && (byte_cnt_q == 4'h3) && (byte1_q == `SR_ADDR_PROTECT);
  assign status_byte = {top_bottom_q, code_q, fail_q, wel_q, busy_now};

  always_ff @(posedge clk) begin
    if (reset) begin
      seen_q         <= 1'b0;
      top_bottom_q   <= 1'(`PROTECT_RESET >> 4);
      code_q         <= 4'(`PROTECT_RESET);
      wel_q          <= 1'b0;
      fail_q         <= 1'b0;
      busy_cnt_q     <= 12'h000;
      array_op_start <= 1'b0;
      array_op_kind  <= OP_NONE;
      page_address   <= 16'h0000;
      protect_reject <= 1'b0;
    end else begin
      if (cs_rise) begin
        seen_q <= tg_lvl_q;
      end
      array_op_start <= array_ok || page_rd_go;
      protect_reject <= array_go && protected_hit;
      // The busy countdown clears the flag once the operation ends
      if (array_ok || page_rd_go) begin
        busy_cnt_q   <= 12'(`BUSY_CYCLES);
        page_address <= page_q;
        array_op_kind <= page_rd_go ? OP_PAGE_READ :
                         (opcode_q == `OP_BLOCK_ERASE) ? OP_ERASE : OP_PROGRAM;
      end else if (busy_now) begin
        busy_cnt_q <= busy_cnt_q - 12'h001;
      end
      if (array_go) begin
        fail_q <= protected_hit;
        wel_q  <= 1'b0;
      end
      if (wrsr_go) begin
        top_bottom_q <= page_q[8 + `SR_TOP_BOTTOM_BIT];
        code_q <= page_q[8 + `SR_CODE_LSB +: 4];
      end
      // Opcodes outside this set are taken and ignored
      if (accepted && whole && byte_cnt_q == 4'h1) begin
        if (opcode_q == `OP_WRITE_ENABLE) begin
          wel_q <= 1'b1;
        end else if (opcode_q == `OP_WRITE_DISABLE || opcode_q == `OP_DEVICE_RESET) begin
          wel_q <= 1'b0;
        end
        if (opcode_q == `OP_DEVICE_RESET) begin
          fail_q <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Core outputs
  // --------------------------------------------------------------------------
  assign busy               = busy_now;
  assign write_enabled      = wel_q;
  assign top_bottom_select  = top_bottom_q;
  assign protect_range_code = code_q;

endmodule : nand_cmd_device

// *** logic/spi_nand_defs.svh ***
// Constants for the serial NAND command front end and its host controller.
// Assumes a 20 MHz core clock on both ends; included by bare name.
`ifndef SPI_NAND_DEFS_SVH
`define SPI_NAND_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     50
`define SCLK_HALF_NS      200
`define SCLK_HALF_CYCLES  ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_GAP_NS         400
`define CS_GAP_CYCLES     ((`CS_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_NS           10000
`define BUSY_CYCLES       ((`BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define OP_DEVICE_RESET   8'hFF
`define OP_READ_ID        8'h9F
`define OP_READ_STATUS    8'h0F
`define OP_WRITE_STATUS   8'h1F
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_BLOCK_ERASE    8'hD8
`define OP_PROGRAM_EXEC   8'h10
`define OP_PAGE_DATA_READ 8'h13

// ----------------------------------------------------------------------------
// Status register addresses and fields
// ----------------------------------------------------------------------------
`define SR_ADDR_PROTECT   8'hA0
`define SR_ADDR_STATUS    8'hC0
`define SR_BUSY_BIT       0
`define SR_WEL_BIT        1
`define SR_FAIL_BIT       2
`define SR_TOP_BOTTOM_BIT 6
`define SR_CODE_LSB       2
`define PROTECT_RESET     5'h00

// ----------------------------------------------------------------------------
// Identification (values are arbitrary)
// ----------------------------------------------------------------------------
`define MAKER_CODE        8'hA5
`define PART_CODE         16'h3C5A

`endif

// *** logic/spi_nand_pkg.sv ***
// Types shared by the NAND command front end and its host controller.
// Assumes nothing of its surroundings.
package spi_nand_pkg;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_ERASE,
    OP_PROGRAM,
    OP_PAGE_READ
  } array_op_t;

  typedef enum logic [2:0] {
    H_IDLE,
    H_LEAD,
    H_SHIFT,
    H_TRAIL,
    H_GAP
  } host_state_t;

endpackage : spi_nand_pkg

// *** logic/spi_link_if.sv ***
// Serial link between the NAND die front end and the host controller.
// Assumes the device gates the data-out wire itself; the enable only feeds the checks.
`timescale 1ns/10ps
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;

  modport device (
    input  cs_n,
    input  sclk,
    input  serial_data_in,
    output serial_data_out,
    output serial_data_out_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output serial_data_in,
    input  serial_data_out,
    input  serial_data_out_oe
  );
endinterface : spi_link_if

// *** logic/nand_host_ctrl.sv ***
// Host end of the serial NAND link: frames one instruction per command.
// Assumes the device samples on rising sclk and shifts out on falling sclk.
`timescale 1ns/10ps
`include "spi_nand_defs.svh"
module nand_host_ctrl (
  // Core clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Link to the device
  spi_link_if.host                   link,
  // Command port
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire logic [7:0]            cmd_opcode,
  input  wire logic [31:0]           cmd_args,
  input  wire logic [2:0]            cmd_bytes,
  input  wire logic [2:0]            cmd_extra_bits,
  // Response port
  output logic                       rsp_valid,
  output logic [31:0]                rsp_data
);
  import spi_nand_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  host_state_t state_q;
  logic        cs_n_q, sclk_q, mosi_q;
  logic [39:0] tx_q;
  logic [6:0]  bits_left_q;
  logic [3:0]  tick_q;
  logic        mi_s1_q, mi_s2_q, mi_s3_q, mi_lvl_q;

  wire half_done = (tick_q == 4'(`SCLK_HALF_CYCLES - 1));
  wire gap_done  = (tick_q == 4'(`CS_GAP_CYCLES - 1));
  // Length counts whole bytes plus a tail, so short frames can be tested
  wire [6:0] bits_total = 7'({cmd_bytes, 3'b000}) + 7'h08 + 7'(cmd_extra_bits);

  assign cmd_ready = (state_q == H_IDLE);
  assign link.cs_n           = cs_n_q;
  assign link.sclk           = sclk_q;
  assign link.serial_data_in = mosi_q;

  // --------------------------------------------------------------------------
  // Input sampling
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      {mi_s1_q, mi_s2_q, mi_s3_q, mi_lvl_q} <= 4'h0;
    end else begin
      {mi_s1_q, mi_s2_q, mi_s3_q} <= {link.serial_data_out, mi_s1_q, mi_s2_q};
      if (mi_s2_q == mi_s3_q) begin
        mi_lvl_q <= mi_s3_q;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Framing
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q     <= H_IDLE;
      cs_n_q      <= 1'b1;
      sclk_q      <= 1'b0;
      mosi_q      <= 1'b0;
      tx_q        <= 40'h00_0000_0000;
      bits_left_q <= 7'h00;
      tick_q      <= 4'h0;
      rsp_valid   <= 1'b0;
      rsp_data    <= 32'h0000_0000;
    end else begin
      rsp_valid <= 1'b0;
      tick_q    <= tick_q + 4'h1;
      case (state_q)
        H_IDLE: begin
          tick_q <= 4'h0;
          if (cmd_valid) begin
            cs_n_q      <= 1'b0;
            tx_q        <= {cmd_opcode, cmd_args};
            mosi_q      <= cmd_opcode[7];
            bits_left_q <= bits_total;
            state_q     <= H_LEAD;
          end
        end
        H_LEAD: begin
          if (half_done) begin
            tick_q  <= 4'h0;
            state_q <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (half_done) begin
            tick_q <= 4'h0;
            sclk_q <= !sclk_q;
            // Read data is taken late in the high phase, after it has settled
            if (sclk_q) begin
              rsp_data    <= {rsp_data[30:0], mi_lvl_q};
              tx_q        <= {tx_q[38:0], 1'b0};
              mosi_q      <= tx_q[38];
              bits_left_q <= bits_left_q - 7'h01;
              if (bits_left_q == 7'h01) begin
                state_q <= H_TRAIL;
              end
            end
          end
        end
        H_TRAIL: begin
          if (half_done) begin
            tick_q    <= 4'h0;
            cs_n_q    <= 1'b1;
            rsp_valid <= 1'b1;
            state_q   <= H_GAP;
          end
        end
        H_GAP: begin
          if (gap_done) begin
            state_q <= H_IDLE;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

endmodule : nand_host_ctrl

// *** dv/spi_link_sva.sv ***
// Wire checks on the serial link between the host controller and the die.
// Assumes the host makes sclk from clk and parks it low between frames.
`timescale 1ns/10ps
module spi_link_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe
);
  // ------------
  // Link timing
  // ------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_idle_clk_low: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  a_frame_lead: assert property ($fell(cs_n) |-> !sclk[*8] ##1 sclk)
    else $error("first sclk rise not eight cycles after select");
  a_clk_high_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("sclk high half wrong");
  a_clk_low_half: assert property ($fell(sclk) |-> !sclk[*4])
    else $error("sclk low half too short");
  a_data_settled: assert property ($rose(sclk) |-> $stable(serial_data_in) && !cs_n)
    else $error("data in moved at sampling edge");
  a_frame_trail: assert property ($rose(cs_n) |-> $past(sclk, 5) && !$past(sclk, 4))
    else $error("select released off the trailing half");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n[*8])
    else $error("deselect gap under eight cycles");
  a_out_released: assert property (cs_n && $past(cs_n) |-> !serial_data_out_oe)
    else $error("data out driven while deselected");
  a_out_on_fall: assert property (serial_data_out_oe && $changed(serial_data_out) |-> !sclk)
    else $error("data out moved outside low half");
endmodule : spi_link_sva

// *** dv/tb_top.sv ***
// Bench for the serial NAND command front end and its host controller.
// Assumes both ends share one 20 MHz clock and meet in spi_link_if.
`timescale 1ns/10ps
`include "spi_nand_defs.svh"
module tb_top;
  import spi_nand_pkg::*;
  // ------------
  // Stimulus and wiring
  // ------------
  logic        clk = 1'b0;
  logic        reset = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [7:0]  cmd_opcode = 8'h00;
  logic [31:0] cmd_args = 32'h0;
  logic [2:0]  cmd_bytes = 3'h0;
  logic [2:0]  cmd_extra_bits = 3'h0;
  logic        cmd_ready, rsp_valid, busy, write_enabled, top_bottom_select;
  logic        array_op_start, protect_reject;
  logic [31:0] rsp_data;
  logic [3:0]  protect_range_code;
  logic [15:0] page_address;
  array_op_t   array_op_kind;
  int          miscompares = 0;
  int          cmp_count = 0;

  always #25 clk = ~clk;

  spi_link_if link ();
  nand_cmd_device nand_cmd_device_inst (.clk(clk), .reset(reset), .link(link.device), .busy(busy),
    .write_enabled(write_enabled), .top_bottom_select(top_bottom_select),
    .protect_range_code(protect_range_code), .array_op_start(array_op_start),
    .array_op_kind(array_op_kind), .page_address(page_address), .protect_reject(protect_reject));
  nand_host_ctrl nand_host_ctrl_inst (.clk(clk), .reset(reset), .link(link.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_args(cmd_args), .cmd_bytes(cmd_bytes),
    .cmd_extra_bits(cmd_extra_bits), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  spi_link_sva spi_link_sva_inst (.clk(clk), .reset(reset), .cs_n(link.cs_n), .sclk(link.sclk),
    .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
    .serial_data_out_oe(link.serial_data_out_oe));

  // ------------
  // Shared tasks
  // ------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One whole frame through the host port; returns once the response lands
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input logic [2:0] nb, input logic [2:0] xb);
    int i;
    for (i = 0; i < 500 && cmd_ready !== 1'b1; i++) tick(1);
    @(posedge clk);
    cmd_valid      <= 1'b1;
    cmd_opcode     <= op;
    cmd_args       <= a;
    cmd_bytes      <= nb;
    cmd_extra_bits <= xb;
    @(posedge clk);
    cmd_valid      <= 1'b0;
    for (i = 0; i < 2000 && rsp_valid !== 1'b1; i++) tick(1);
    chk("rsp_valid", rsp_valid, 32'h1);
  endtask : cmd

  task automatic status(input logic [2:0] exp);
    cmd(`OP_READ_STATUS, {`SR_ADDR_STATUS, 24'h0}, 3'h2, 3'h0);
    chk("status", rsp_data[2:0], exp);
  endtask : status

  task automatic wait_idle;
    int i;
    for (i = 0; i < 400 && busy !== 1'b0; i++) tick(1);
    chk("busy", busy, 32'h0);
  endtask : wait_idle

  task automatic set_prot(input logic sel, input logic [3:0] code);
    cmd(`OP_WRITE_ENABLE, 32'h0, 3'h0, 3'h0);
    cmd(`OP_WRITE_STATUS, {`SR_ADDR_PROTECT, 1'b0, sel, code, 2'b00, 16'h0}, 3'h2, 3'h0);
    tick(8);
    chk("top_bottom", top_bottom_select, sel);
    chk("code", protect_range_code, code);
    cmd(`OP_READ_STATUS, {`SR_ADDR_PROTECT, 24'h0}, 3'h2, 3'h0);
    chk("protect_reg", rsp_data[7:0], {1'b0, sel, code, 2'b00});
  endtask : set_prot

  // Page sits at the top of the block so the low six bits cannot matter
  task automatic array_try(input logic [7:0] op, input logic [9:0] blk, input logic rej, input array_op_t kind);
    int   i;
    logic s;
    logic r;
    s = 1'b0;
    r = 1'b0;
    cmd(`OP_WRITE_ENABLE, 32'h0, 3'h0, 3'h0);
    cmd(op, {8'h00, blk, 6'h3F, 8'h00}, 3'h3, 3'h0);
    for (i = 0; i < 20; i++) begin
      tick(1);
      s = s | array_op_start;
      r = r | protect_reject;
    end
    chk("reject", r, rej);
    chk("start", s, !rej);
    if (!rej) begin
      chk("page", page_address, {blk, 6'h3F});
      chk("kind", array_op_kind, kind);
    end
    wait_idle();
  endtask : array_try

  function automatic logic prot(input int t, input int n, input int b);
    return t ? (b < n) : (b >= 1024 - n);
  endfunction : prot

  // ------------
  // Scenarios
  // ------------
  task automatic check_alignment;
    cmd(`OP_WRITE_DISABLE, 32'h0, 3'h0, 3'h0);
    cmd(`OP_WRITE_ENABLE, 32'h0, 3'h0, 3'h3);
    tick(8);
    chk("wel_odd", write_enabled, 32'h0);
    cmd(`OP_READ_STATUS, {`SR_ADDR_STATUS, 24'h0}, 3'h1, 3'h5);
    cmd(`OP_WRITE_ENABLE, 32'h0, 3'h0, 3'h0);
    tick(8);
    chk("wel", write_enabled, 32'h1);
    status(3'b010);
  endtask : check_alignment

  // Boundary blocks on both sides of the ranges for codes 0, 1, 5, 9, A and E, both directions
  task automatic check_protection;
    logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'hA, 4'hE};
    logic [3:0] c;
    logic [9:0] b;
    int         n;
    for (int t = 0; t < 2; t++) begin
      for (int k = 0; k < 6; k++) begin
        c = codes[k];
        n = (c[3] && (c[2] || c[1])) ? 1024 : ((c == 4'h0) ? 0 : (1 << c));
        set_prot(t[0], c);
        b = 10'(t ? n - 1 : 1024 - n);
        array_try(`OP_BLOCK_ERASE, b, prot(t, n, b), OP_ERASE);
        b = 10'(t ? n : 1023 - n);
        array_try(`OP_PROGRAM_EXEC, b, prot(t, n, b), OP_PROGRAM);
      end
    end
    status(3'b100);
    cmd(`OP_DEVICE_RESET, 32'h0, 3'h0, 3'h0);
    status(3'b000);
    array_try(`OP_PAGE_DATA_READ, 10'h003, 1'b0, OP_PAGE_READ);
    set_prot(1'b0, 4'h0);
  endtask : check_protection

  // Write enable sent while busy must vanish; the ID read must still answer
  task automatic check_busy;
    cmd(`OP_WRITE_ENABLE, 32'h0, 3'h0, 3'h0);
    cmd(`OP_BLOCK_ERASE, {8'h00, 10'h007, 6'h00, 8'h00}, 3'h3, 3'h0);
    tick(10);
    chk("busy_run", busy, 32'h1);
    cmd(`OP_WRITE_ENABLE, 32'h0, 3'h0, 3'h0);
    cmd(`OP_READ_ID, 32'h0, 3'h4, 3'h0);
    chk("ident", rsp_data[23:0], {`MAKER_CODE, `PART_CODE});
    chk("wel_busy", write_enabled, 32'h0);
    wait_idle();
    status(3'b000);
  endtask : check_busy

  task automatic end_sim;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  initial begin
    // Raised by a nonblocking update at time zero so the link side's asynchronous clear sees an edge
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    tick(2);
    check_alignment();
    check_protection();
    check_busy();
    end_sim();
  end

  // Whole run needs roughly 20000 cycles
  initial begin
    tick(60000);
    miscompares++;
    end_sim();
  end
endmodule : tb_top
